// ---- logic/dual_channel_switch.v ----
// dual channel interface switch with axi4-lite status and address registers
// Contract
// - valid reserve (f4) locks switch to issuing channel until its release or reset
// - valid release (d4) clears reservation; either channel may use the unit again
// - resets are taken only from the operating channel
// - own address with unit neither busy nor reserved sets that operational-in
// - selection from the other channel while busy or reserved gets short busy
// - a channel refused with short busy later receives control unit end status
// - simultaneous selection grants exactly one channel, the other is refused
// - reserve or release while chained is not executed; command reject is flagged
// - modifier bit 2 of the sense byte chooses reserve (set) or release (clear)
// - unchained reserve sets flag 20 in the first flags word
// - valid reserve sets channel tags in bit 2, keeping switched-to latch on
// - valid release leaves tags bit 2 clear; latches drop at chain end
// - address match with address-out clears select-out; with cue off gives trap
// - trap with select sets switched-to; with delayed select gives initial selection
// - selection from the other channel while held sets its cue latch
// - at finish, flagged channels get cue status, device end merged if present
// - disabled channel bypasses select-out and is degated; both disabled is offline
// - unreserved connection ends with the last command of the chain
// - stacked primary, or secondary with uc or ue, holds until status accepted
// - other stacked secondary frees switch; later presentation obeys suppress-out
// - unit check ending makes a contingent connection until a real command
// - in contingent state tio or nop to another unit gets short busy, kept
// - short busy is bits 1 and 3 plus parity on bus-in with status-in only
`timescale 1ns/10ps
`include "dcs_consts.vh"
module dual_channel_switch (
  input wire i_core_clk,
  input wire i_rst,
  // channel a/b interface tags and bus-out
  input wire [7:0] i_bus_out_a,
  input wire [7:0] i_bus_out_b,
  input wire [1:0] i_addr_out,
  input wire [1:0] i_select,
  input wire [1:0] i_sys_reset,
  input wire [1:0] i_suppress_out,
  input wire [1:0] i_enable,
  // control unit common side
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_byte,
  input wire i_chained,
  input wire i_other_unit,
  input wire i_unit_ready,
  input wire i_chain_end,
  input wire i_status_uc,
  input wire i_status_ue,
  input wire i_stack_primary,
  input wire i_stack_secondary,
  input wire i_status_accepted,
  input wire i_dev_end,
  input wire i_cue_ack,
  // axi4-lite slave
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // channel outputs
  output reg [1:0] o_op_in,
  output reg [1:0] o_sw_to,
  output reg [1:0] o_init_sel,
  output reg [1:0] o_status_in,
  output reg [8:0] o_bus_in_a,
  output reg [8:0] o_bus_in_b,
  output reg [1:0] o_cue_pending,
  output reg o_cmd_reject,
  output reg o_reserved,
  output reg o_offline
);
  reg [7:0] cu_addr_q;
  reg [1:0] sw_q;
  reg [1:0] dly_sel_q;
  reg [7:0] flags_q;
  reg [7:0] tags_q;
  reg hold_q;
  reg cont_q;
  reg done_q;
  reg [1:0] stk2_q;
  reg [1:0] cue_busy_q;
  wire [1:0] match;
  wire [1:0] trap;
  wire [1:0] refused;
  wire [1:0] cue_q;
  wire [1:0] cue_done;
  wire [1:0] other_holds;
  wire [1:0] set_sw;
  wire [1:0] rst_ok;
  wire neutral;
  wire reserved;
  wire is_sense;
  wire is_tio_nop;
  wire free;
  wire [1:0] cont_busy;

  assign reserved = tags_q[`DCS_TAGS_HOLD_BIT];
  assign neutral = (sw_q == 2'b00);
  assign match[0] = i_addr_out[0] && (i_bus_out_a == cu_addr_q);
  assign match[1] = i_addr_out[1] && (i_bus_out_b == cu_addr_q);
  // a reset counts only from the channel that holds the switch
  assign rst_ok = i_sys_reset & sw_q;
  // connection may drop once the chain is done and nothing keeps it
  assign free = done_q && !reserved && !hold_q && !cont_q;
  assign is_sense = ((i_cmd_byte & `DCS_SENSE_MASK) == `DCS_CMD_RELEASE);
  assign is_tio_nop = (i_cmd_byte == `DCS_CMD_TIO) || (i_cmd_byte == `DCS_CMD_NOP);
  assign cont_busy = {2{i_cmd_valid && cont_q && is_tio_nop && i_other_unit}} & sw_q;

  // tie-breaker: channel a wins a same-cycle race, b is then refused
  assign set_sw[0] = neutral && trap[0] && i_select[0];
  assign set_sw[1] = neutral && trap[1] && i_select[1] && !set_sw[0];
  assign other_holds[0] = sw_q[1] || set_sw[1];
  assign other_holds[1] = sw_q[0] || set_sw[0];
  assign cue_done = {2{i_cue_ack}} & cue_busy_q;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_front
      chan_front u_front (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_match(match[c]),
        .i_addr_out(i_addr_out[c]),
        .i_enable(i_enable[c]),
        .i_op_in(o_op_in[c]),
        .i_other_holds(other_holds[c]),
        .i_cue_done(cue_done[c]),
        .o_trap(trap[c]),
        .o_refused(refused[c]),
        .o_cue_q(cue_q[c])
      );
    end
  endgenerate

  // switched-to latches, delayed select and operational-in
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_q <= 2'b00;
      dly_sel_q <= 2'b00;
      o_sw_to <= 2'b00;
      o_init_sel <= 2'b00;
      o_op_in <= 2'b00;
    end else begin
      dly_sel_q <= i_select;
      if (|rst_ok || free || (sw_q & ~i_enable) != 2'b00) begin
        sw_q <= 2'b00;
      end else begin
        sw_q <= sw_q | set_sw;
      end
      o_sw_to <= sw_q;
      o_init_sel <= sw_q & dly_sel_q & i_select & ~o_op_in;
      if (|rst_ok || free || i_chain_end) begin
        o_op_in <= 2'b00;
      end else begin
        o_op_in <= o_op_in | (sw_q & dly_sel_q & i_enable);
      end
    end
  end

  // reserve/release command decode and local storage
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= 8'h00;
      tags_q <= 8'h00;
      o_cmd_reject <= 1'b0;
    end else begin
      o_cmd_reject <= 1'b0;
      if (|rst_ok) begin
        // reset from the owner drops its reservation
        flags_q <= flags_q & ~`DCS_RESERVE_FLAG;
        tags_q[`DCS_TAGS_HOLD_BIT] <= 1'b0;
      end else if (i_cmd_valid && is_sense && !neutral) begin
        if (i_chained) begin
          o_cmd_reject <= 1'b1;
        end else if (i_cmd_byte[`DCS_MOD_BIT]) begin
          flags_q <= flags_q | `DCS_RESERVE_FLAG;
          tags_q[`DCS_TAGS_HOLD_BIT] <= 1'b1;
        end else begin
          flags_q <= flags_q & ~`DCS_RESERVE_FLAG;
          tags_q[`DCS_TAGS_HOLD_BIT] <= 1'b0;
        end
      end
    end
  end

  // chain end, stacked status hold and contingent connection
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
      hold_q <= 1'b0;
      cont_q <= 1'b0;
      stk2_q <= 2'b00;
    end else begin
      // a new command means the chain runs on, so a stale done cannot free a later release
      if (|set_sw || |rst_ok || free || i_cmd_valid) begin
        done_q <= 1'b0;
      end else if (i_chain_end) begin
        done_q <= 1'b1;
      end
      // a new stack wins over an acceptance landing in the same cycle
      if (|rst_ok) begin
        hold_q <= 1'b0;
      end else if (i_chain_end && (i_stack_primary ||
                   (i_stack_secondary && (i_status_uc || i_status_ue)))) begin
        hold_q <= 1'b1;
      end else if (i_status_accepted) begin
        hold_q <= 1'b0;
      end
      if (|rst_ok) begin
        cont_q <= 1'b0;
      end else if (i_chain_end && i_status_uc) begin
        cont_q <= 1'b1;
      end else if (i_cmd_valid && !is_tio_nop && i_unit_ready) begin
        cont_q <= 1'b0;
      end
      // plain stacked secondary is parked per channel, switch goes free
      if (i_chain_end && i_stack_secondary && !i_status_uc && !i_status_ue) begin
        stk2_q <= stk2_q | sw_q;
      end else begin
        stk2_q <= stk2_q & ~(o_status_in & ~cue_busy_q);
      end
    end
  end

  // bus-in drive: short busy, cue status or parked secondary status
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status_in <= 2'b00;
      o_bus_in_a <= 9'h000;
      o_bus_in_b <= 9'h000;
      cue_busy_q <= 2'b00;
      o_cue_pending <= 2'b00;
      o_reserved <= 1'b0;
      o_offline <= 1'b1;
    end else begin
      o_cue_pending <= cue_q;
      o_reserved <= reserved;
      o_offline <= (i_enable == 2'b00);
      o_status_in <= 2'b00;
      o_bus_in_a <= 9'h000;
      o_bus_in_b <= 9'h000;
      cue_busy_q <= cue_busy_q & ~cue_done;
      if (refused[0] || cont_busy[0]) begin
        o_status_in[0] <= 1'b1;
        o_bus_in_a <= `DCS_SHORT_BUSY;
      end else if (neutral && !i_select[1] && cue_q[0] && cue_busy_q == 2'b00) begin
        o_status_in[0] <= 1'b1;
        o_bus_in_a <= i_dev_end ? `DCS_CUE_DE_STAT : `DCS_CUE_STAT;
        cue_busy_q[0] <= 1'b1;
      end else if (neutral && stk2_q[0] && !i_suppress_out[0]) begin
        o_status_in[0] <= 1'b1;
      end
      if (refused[1] || cont_busy[1]) begin
        o_status_in[1] <= 1'b1;
        o_bus_in_b <= `DCS_SHORT_BUSY;
      end else if (neutral && !i_select[0] && cue_q[1] && cue_busy_q == 2'b00 && !cue_q[0]) begin
        o_status_in[1] <= 1'b1;
        o_bus_in_b <= i_dev_end ? `DCS_CUE_DE_STAT : `DCS_CUE_STAT;
        cue_busy_q[1] <= 1'b1;
      end else if (neutral && stk2_q[1] && !i_suppress_out[1]) begin
        o_status_in[1] <= 1'b1;
      end
    end
  end

  // axi write: address and data taken in either order, answer after both
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `DCS_RESP_OKAY;
      cu_addr_q <= `DCS_ADDR_RST;
    end else begin
      o_awready <= !aw_have_q && !o_awready && i_awvalid && !o_bvalid;
      o_wready <= !w_have_q && !o_wready && i_wvalid && !o_bvalid;
      if (o_awready && i_awvalid) begin
        aw_have_q <= 1'b1;
        aw_q <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_have_q <= 1'b1;
        w_q <= i_wdata;
        ws_q <= i_wstrb;
      end
      if (aw_have_q && w_have_q && !o_bvalid) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_bvalid <= 1'b1;
        if (aw_q == `DCS_OFF_ADDR) begin
          o_bresp <= `DCS_RESP_OKAY;
          if (ws_q[0]) begin
            cu_addr_q <= w_q[7:0]; // unit address steers both decoders
          end
        end else if (aw_q == `DCS_OFF_STAT || aw_q == `DCS_OFF_FLAGS ||
                     aw_q == `DCS_OFF_TAGS) begin
          o_bresp <= `DCS_RESP_OKAY; // read-only, write ignored
        end else begin
          o_bresp <= `DCS_RESP_SLVERR;
        end
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // axi read: one-cycle accept, data registered the cycle after
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `DCS_RESP_OKAY;
    end else begin
      o_arready <= !o_arready && !o_rvalid && i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp <= `DCS_RESP_OKAY;
        case (i_araddr)
          `DCS_OFF_ADDR: o_rdata <= {24'h000000, cu_addr_q};
          `DCS_OFF_STAT: o_rdata <= {22'h0, stk2_q, cont_q, hold_q,
                                     cue_q, reserved, o_offline, sw_q};
          `DCS_OFF_FLAGS: o_rdata <= {24'h000000, flags_q};
          `DCS_OFF_TAGS: o_rdata <= {24'h000000, tags_q};
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `DCS_RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- logic/dcs_consts.vh ----
// constants for the dual channel interface switch
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// axi4-lite register byte offsets
`define DCS_OFF_ADDR 8'h00
`define DCS_OFF_STAT 8'h04
`define DCS_OFF_FLAGS 8'h08
`define DCS_OFF_TAGS 8'h0c
`define DCS_OFF_CTRL 8'h10
// reset values
`define DCS_ADDR_RST 8'h00
// command codes
`define DCS_CMD_RESERVE 8'hf4
`define DCS_CMD_RELEASE 8'hd4
`define DCS_SENSE_MASK 8'hdf
`define DCS_CMD_TIO 8'h00
`define DCS_CMD_NOP 8'h03
// modifier bit 2 (msb-first numbering) sits at byte position 5
`define DCS_MOD_BIT 5
// reserve flag value in the first flags word
`define DCS_RESERVE_FLAG 8'h20
// channel tags in bit 2 (msb-first) at byte position 5
`define DCS_TAGS_HOLD_BIT 5
// status bytes with parity in bit 8
`define DCS_SHORT_BUSY 9'h150
`define DCS_CUE_STAT 9'h020
`define DCS_DE_STAT 9'h004
// cue with device end carries two data bits, so odd parity sets bit 8
`define DCS_CUE_DE_STAT 9'h124
// axi responses
`define DCS_RESP_OKAY 2'b00
`define DCS_RESP_SLVERR 2'b10
`endif

// ---- logic/chan_front.v ----
// per-channel selection front end: select-out latch, trap and cue latch
`timescale 1ns/10ps
`include "dcs_consts.vh"
module chan_front (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_match,
  input wire i_addr_out,
  input wire i_enable,
  input wire i_op_in,
  input wire i_other_holds,
  input wire i_cue_done,
  output wire o_trap,
  output wire o_refused,
  output reg o_cue_q
);
  reg sel_out_q;

  // select-out latch rests set while the interface is idle; disabled bypasses it
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_out_q <= 1'b1;
    end else if (!i_enable) begin
      sel_out_q <= 1'b1;
    end else if (i_match) begin
      sel_out_q <= 1'b0;
    end else if (!i_addr_out && !i_op_in) begin
      sel_out_q <= 1'b1;
    end
  end

  // cue latch remembers a refused attempt until its cue status has been acknowledged
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cue_q <= 1'b0;
    end else if (o_refused) begin
      o_cue_q <= 1'b1;
    end else if (i_cue_done) begin
      o_cue_q <= 1'b0;
    end
  end

  assign o_trap = !sel_out_q && !o_cue_q && i_enable;
  assign o_refused = i_match && i_other_holds && i_enable;
endmodule

// ---- verif/dcs_assertions.sv ----
// port-level concurrent checks for the dual channel switch
`timescale 1ns/10ps
`include "dcs_consts.vh"
module dcs_assertions (
  input wire i_core_clk,
  input wire i_rst,
  input wire [1:0] i_select,
  input wire [1:0] i_sys_reset,
  input wire [1:0] i_enable,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_byte,
  input wire i_chained,
  input wire [1:0] o_sw_to,
  input wire [1:0] o_init_sel,
  input wire [1:0] o_status_in,
  input wire [8:0] o_bus_in_b,
  input wire [1:0] o_cue_pending,
  input wire o_cmd_reject,
  input wire o_reserved,
  input wire o_offline
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // commands only count while some channel holds the switch
  wire held = |o_sw_to;
  wire resv = i_cmd_valid && !i_chained && held && i_cmd_byte == `DCS_CMD_RESERVE;
  wire rels = i_cmd_valid && !i_chained && held && i_cmd_byte == `DCS_CMD_RELEASE;
  wire chnd = i_cmd_valid && i_chained && held && i_cmd_byte == `DCS_CMD_RELEASE;
  // grant of channel a, and a break-in attempt by b while a has held for a cycle
  sequence granted_a;
    $rose(o_sw_to[0]) && i_select[0];
  endsequence
  sequence refused_b;
    o_sw_to[0] && $past(o_sw_to[0]) && o_status_in[1];
  endsequence
  a_one_owner: assert property (!(o_sw_to[0] && o_sw_to[1]))
    else $error("both switched-to latches on");
  a_init_select: assert property (granted_a |-> ##[0:1] o_init_sel[0])
    else $error("no initial selection after grant");
  a_busy_byte: assert property (refused_b |-> o_bus_in_b == `DCS_SHORT_BUSY)
    else $error("refused channel got wrong status byte");
  a_cue_record: assert property (refused_b |-> ##[0:1] o_cue_pending[1])
    else $error("refused channel not recorded");
  a_reserve_lock: assert property (resv |=> ##1 o_reserved)
    else $error("reserve did not lock");
  a_release_free: assert property (rels |=> ##1 !o_reserved)
    else $error("release did not unlock");
  a_chain_reject: assert property (chnd |=> o_cmd_reject ##1 $stable(o_reserved))
    else $error("chained release not rejected");
  a_foreign_reset: assert property (o_reserved && o_sw_to[0] && i_sys_reset == 2'b10
    && i_enable[0] && !i_cmd_valid |=> o_reserved)
    else $error("reset from idle channel broke reservation");
  a_degate_off: assert property (!i_enable[0] [*4] |-> !o_sw_to[0])
    else $error("disabled channel still switched");
  a_both_off: assert property (i_enable == 2'b00 |=> o_offline)
    else $error("not offline with both disabled");
endmodule

// ---- verif/host_chan.sv ----
// behavioural host channel driving address-out, select and bus-out
`timescale 1ns/10ps
module host_chan (
  input wire i_core_clk,
  input wire i_req,
  input wire [7:0] i_addr,
  output logic [7:0] o_bus_out,
  output logic o_addr_out,
  output logic o_select
);
  // start idle with a bus value that is not a unit address
  initial begin
    o_bus_out = 8'h5a;
    o_addr_out = 1'b0;
    o_select = 1'b0;
  end
  // tags held while asked; a released bus flips so a stale address never looks valid
  always @(posedge i_core_clk) begin
    o_select <= i_req;
    o_addr_out <= i_req;
    o_bus_out <= i_req ? i_addr : ~o_bus_out;
  end
endmodule

// ---- verif/dual_channel_switch_tb.sv ----
// self-checking bench for the dual channel switch
`timescale 1ns/10ps
`include "dcs_consts.vh"
module dual_channel_switch_tb;
  localparam logic [7:0] unit_addr = 8'h3a;
  logic i_core_clk, i_rst, i_cmd_valid, i_chained, i_other_unit, i_unit_ready, i_chain_end;
  logic i_status_uc, i_status_ue, i_stack_primary, i_stack_secondary, i_status_accepted;
  logic i_dev_end, i_cue_ack, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic req_a, req_b, rej;
  logic [1:0] i_sys_reset, i_suppress_out, i_enable, rsp;
  logic [7:0] i_cmd_byte, i_awaddr, i_araddr;
  logic [31:0] i_wdata, rd;
  logic [3:0] i_wstrb;
  wire [7:0] i_bus_out_a, i_bus_out_b;
  wire [1:0] i_addr_out, i_select, o_op_in, o_sw_to, o_init_sel, o_status_in, o_cue_pending;
  wire [1:0] o_bresp, o_rresp;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cmd_reject, o_reserved, o_offline;
  wire [31:0] o_rdata;
  wire [8:0] o_bus_in_a, o_bus_in_b;
  wire [4:0] fl = {o_cue_pending[1], o_status_in, o_sw_to};
  int error_cnt = 0;
  int check_count = 0;
  int i;

  dual_channel_switch i_dut (.*);
  host_chan i_host_a (.i_core_clk, .i_req(req_a), .i_addr(unit_addr),
    .o_bus_out(i_bus_out_a), .o_addr_out(i_addr_out[0]), .o_select(i_select[0]));
  host_chan i_host_b (.i_core_clk, .i_req(req_b), .i_addr(unit_addr),
    .o_bus_out(i_bus_out_b), .o_addr_out(i_addr_out[1]), .o_select(i_select[1]));

  // free-running core clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // comparisons are made at the edge, before that edge's register updates land
  task tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task wrap_up;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task tmo(input string nm);
    error_cnt++;
    $display("[FAIL] %s expected done seen timeout", nm);
    wrap_up;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait for one watched flag, bounded
  task wt(input int k, input logic v);
    int n;
    check_count++;
    for (n = 0; n < 60 && fl[k] !== v; n++) tick(1);
    if (fl[k] !== v) tmo("flag wait");
  endtask
  // axi4-lite master: valid held until its ready, response taken at the edge
  task axw(input [7:0] a, input [31:0] d, output logic [1:0] r);
    int n;
    tick(1);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hf;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      tick(1);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    if (n == 50) tmo("axi write");
    r = o_bresp;
    i_bready <= 1'b0;
  endtask
  task axr(input [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    tick(1);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      tick(1);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    if (n == 50) tmo("axi read");
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask
  // one command pulse; f = {chained, other unit, unit ready}
  task cmd(input [7:0] b, input [2:0] f, output logic rj);
    tick(1);
    i_cmd_valid <= 1'b1;
    i_cmd_byte <= b;
    {i_chained, i_other_unit, i_unit_ready} <= f;
    tick(1);
    i_cmd_valid <= 1'b0;
    tick(1);
    rj = o_cmd_reject;
  endtask
  // chain end pulse; f = {unit check, unit exception, primary stack, secondary stack}
  task ce(input [3:0] f);
    tick(1);
    i_chain_end <= 1'b1;
    {i_status_uc, i_status_ue, i_stack_primary, i_stack_secondary} <= f;
    tick(1);
    i_chain_end <= 1'b0;
  endtask
  task accept;
    tick(1);
    i_status_accepted <= 1'b1;
    tick(1);
    i_status_accepted <= 1'b0;
  endtask

  // main sequence; device end stays low
  initial begin
    {i_cmd_valid, i_chained, i_other_unit, i_unit_ready, i_chain_end, i_status_uc} = '0;
    {i_status_ue, i_stack_primary, i_stack_secondary, i_status_accepted, i_dev_end} = '0;
    {i_cue_ack, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, req_a, req_b} = '0;
    {i_sys_reset, i_suppress_out, i_cmd_byte, i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    i_enable = 2'b11;
    i_rst = 1'b1;
    tick(6);
    i_rst <= 1'b0;
    axr(`DCS_OFF_ADDR, rd, rsp);
    chk("addr reset", rd, 32'h0);
    axw(`DCS_OFF_ADDR, {24'h0, unit_addr}, rsp);
    axr(`DCS_OFF_ADDR, rd, rsp);
    chk("addr readback", rd, {24'h0, unit_addr});
    axw(8'h40, 32'h1, rsp);
    chk("unmapped write", rsp, `DCS_RESP_SLVERR);
    axr(8'h40, rd, rsp);
    chk("unmapped read", rsp, `DCS_RESP_SLVERR);
    // both channels select at once: a wins, b is refused
    req_a <= 1'b1;
    req_b <= 1'b1;
    wt(0, 1'b1);
    chk("init sel a", o_init_sel[0], 1'b1);
    chk("b not switched", o_sw_to[1], 1'b0);
    wt(3, 1'b1);
    chk("short busy b", o_bus_in_b, `DCS_SHORT_BUSY);
    req_b <= 1'b0;
    tick(1);
    chk("cue b set", o_cue_pending[1], 1'b1);
    chk("op in a", o_op_in[0], 1'b1);
    // reserve, chained release, foreign reset, chain end, then release
    cmd(`DCS_CMD_RESERVE, 3'b000, rej);
    tick(1);
    chk("reserved", o_reserved, 1'b1);
    axr(`DCS_OFF_FLAGS, rd, rsp);
    chk("flags word", rd, `DCS_RESERVE_FLAG);
    axr(`DCS_OFF_TAGS, rd, rsp);
    chk("tags hold", rd[`DCS_TAGS_HOLD_BIT], 1'b1);
    cmd(`DCS_CMD_RELEASE, 3'b100, rej);
    chk("chained reject", rej, 1'b1);
    chk("still reserved", o_reserved, 1'b1);
    i_sys_reset <= 2'b10;
    tick(1);
    i_sys_reset <= 2'b00;
    ce(4'h0);
    tick(3);
    chk("b reset ignored", o_reserved, 1'b1);
    chk("held by reserve", o_sw_to[0], 1'b1);
    cmd(`DCS_CMD_RELEASE, 3'b000, rej);
    tick(1);
    chk("released", o_reserved, 1'b0);
    axr(`DCS_OFF_TAGS, rd, rsp);
    chk("tags clear", rd[`DCS_TAGS_HOLD_BIT], 1'b0);
    // chain end frees a, b then gets control unit end
    ce(4'h0);
    req_a <= 1'b0;
    wt(0, 1'b0);
    wt(3, 1'b1);
    chk("cue to b", o_bus_in_b, `DCS_CUE_STAT);
    i_cue_ack <= 1'b1;
    tick(1);
    i_cue_ack <= 1'b0;
    wt(4, 1'b0);
    // unit check gives a contingent connection
    req_a <= 1'b1;
    wt(0, 1'b1);
    ce(4'b1010);
    accept;
    tick(3);
    chk("contingent held", o_sw_to[0], 1'b1);
    for (i = 0; i < 2; i++) begin
      cmd(i ? `DCS_CMD_NOP : `DCS_CMD_TIO, 3'b011, rej);
      wt(2, 1'b1);
      chk("busy a", o_bus_in_a, `DCS_SHORT_BUSY);
    end
    cmd(8'h01, 3'b001, rej);
    ce(4'h0);
    req_a <= 1'b0;
    wt(0, 1'b0);
    // secondary with unit exception holds until accepted, plain secondary frees
    req_a <= 1'b1;
    wt(0, 1'b1);
    ce(4'b0101);
    req_a <= 1'b0;
    tick(4);
    chk("held for ue", o_sw_to[0], 1'b1);
    accept;
    wt(0, 1'b0);
    req_a <= 1'b1;
    wt(0, 1'b1);
    i_suppress_out <= 2'b01;
    ce(4'b0001);
    req_a <= 1'b0;
    wt(0, 1'b0);
    tick(3);
    axr(`DCS_OFF_STAT, rd, rsp);
    chk("secondary parked", rd[8], 1'b1);
    i_suppress_out <= 2'b00;
    wt(2, 1'b1);
    // owner reset drops its own reservation and the switch
    req_a <= 1'b1;
    wt(0, 1'b1);
    cmd(`DCS_CMD_RESERVE, 3'b000, rej);
    req_a <= 1'b0;
    tick(4);
    chk("reserve kept", o_reserved, 1'b1);
    i_sys_reset <= 2'b01;
    tick(1);
    i_sys_reset <= 2'b00;
    tick(3);
    chk("owner reset frees", o_sw_to[0], 1'b0);
    chk("owner reset unlocks", o_reserved, 1'b0);
    // partitioning
    i_enable <= 2'b10;
    req_a <= 1'b1;
    tick(8);
    chk("disabled a", o_sw_to[0], 1'b0);
    i_enable <= 2'b00;
    tick(2);
    chk("offline", o_offline, 1'b1);
    wrap_up;
  end
endmodule

bind dual_channel_switch dcs_assertions i_chk (.*);
